// File: core/supply_switch_pkg.sv
// Constants shared by the card supply switch decoder
package supply_switch_pkg;
	localparam int WORD_BITS = 11;
	localparam int BITCNT_W = 4;
	// Control word field positions
	localparam int POS_A_PROG_LO = 0;
	localparam int POS_A_PROG_HI = 1;
	localparam int POS_A_CARD_HI = 3;
	localparam int POS_A_CARD_LO = 2;
	localparam int POS_B_PROG_LO = 4;
	localparam int POS_B_PROG_HI = 5;
	localparam int POS_B_CARD_HI = 6;
	localparam int POS_B_CARD_LO = 7;
	localparam int POS_OUTPUTS_OFF = 8;
	localparam int POS_A_LEVEL = 9;
	localparam int POS_B_LEVEL = 10;
	// Output selection codes
	localparam logic [2:0] SEL_GROUND = 3'h0;
	localparam logic [2:0] SEL_3V3 = 3'h1;
	localparam logic [2:0] SEL_5V = 3'h2;
	localparam logic [2:0] SEL_12V = 3'h3;
	localparam logic [2:0] SEL_HIZ = 3'h4;
	localparam logic [2:0] SEL_ZERO = 3'h5;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 11'h000;
endpackage : supply_switch_pkg

// File: core/card_power_switch_decoder.sv
// Serial control word capture and supply selection decoder for two card slots
// What this block does
// - Mode pin high: program supply decoded from its own bits, independent of card supply.
// - Mode pin low: legacy decode, program supply may follow card supply.
// - Independent slot A program: 00 zero, 01 3.3/5 by level, 10 12 V, 11 Hi-Z.
// - Independent slot B program: same decode using its own bits and level select.
// - Slot A card supply: 01 3.3 V, 10 5 V, 00 and 11 zero volts.
// - Slot B card supply: 01 3.3 V, 10 5 V, 00 and 11 zero volts.
// - Legacy slot A program: 00 zero, 01 follows card, 10 12 V, 11 Hi-Z.
// - Legacy slot B program: 00 zero, 01 follows card, 10 12 V, 11 Hi-Z.
// - Serial data captured on rising serial clock into an eleven-bit word.
// - Latch rising edge moves the shifted word to the decoders.
// - Reset grounds all outputs and blocks latching until released and relatched.
// - Outputs-off bit at zero forces every supply output to high impedance.
module card_power_switch_decoder
	import supply_switch_pkg::*;
(
	input wire logic clk, // System clock, 40 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic ser_clk, // Serial clock from the host controller
	input wire logic ser_data, // Serial data, sampled on ser_clk rise
	input wire logic ser_latch, // Latch strobe, rising edge loads the word
	input wire logic mode_independent, // High: independent program supply decode
	input wire logic reset_hi, // Device reset input, active high
	input wire logic reset_lo_n, // Device reset input, active low
	output logic [2:0] slot_a_prog_voltage, // Slot A program supply selection
	output logic [2:0] slot_b_prog_voltage, // Slot B program supply selection
	output logic [2:0] slot_a_card_voltage, // Slot A card supply selection
	output logic [2:0] slot_b_card_voltage, // Slot B card supply selection
	output logic word_valid // A word has been latched since reset
);

	// Program supply decode; legacy 01 follows the card supply
	function automatic logic [2:0] prog_decode(input logic [1:0] bits, input logic level,
			input logic indep, input logic [2:0] card);
		logic [2:0] sel;
		sel = SEL_GROUND;
		case (bits)
			2'b00: sel = SEL_ZERO;
			2'b01: sel = indep ? (level ? SEL_5V : SEL_3V3) : card;
			2'b10: sel = SEL_12V;
			default: sel = SEL_HIZ;
		endcase
		return sel;
	endfunction : prog_decode

	function automatic logic [2:0] card_decode(input logic [1:0] bits);
		logic [2:0] sel;
		sel = SEL_ZERO;
		case (bits)
			2'b01: sel = SEL_3V3;
			2'b10: sel = SEL_5V;
			default: sel = SEL_ZERO;
		endcase
		return sel;
	endfunction : card_decode

	// Link domain: shifter plus latch-edge toggle
	typedef struct packed {
		logic [WORD_BITS-1:0] shift;
		logic [WORD_BITS-1:0] held;
		logic toggle;
		logic latch_q;
		logic [1:0] rh_sync;
		logic [1:0] rl_sync;
	} link_s;

	typedef struct packed {
		logic [2:0] tog_sync;
		logic [1:0] mode_sync;
		logic [1:0] rh_sync;
		logic [1:0] rl_sync;
		logic [WORD_BITS-1:0] word;
		logic valid;
		logic [2:0] a_prog;
		logic [2:0] b_prog;
		logic [2:0] a_card;
		logic [2:0] b_card;
	} core_s;

	link_s link;
	link_s next_link;
	core_s st;
	core_s next_st;
	logic dev_reset_link;

	// Each reset pin is synchronised on its own so a pin edge cannot glitch the gate
	assign dev_reset_link = link.rh_sync[1] | ~link.rl_sync[1];

	always_comb begin
		next_link = link;
		next_link.rh_sync = {link.rh_sync[0], reset_hi};
		next_link.rl_sync = {link.rl_sync[0], reset_lo_n};
		next_link.shift = {link.shift[WORD_BITS-2:0], ser_data};
		// Latch sampled on ser_clk; host raises it before the next clock rise
		next_link.latch_q = ser_latch;
		if (ser_latch && !link.latch_q && !dev_reset_link) begin
			next_link.held = link.shift;
			next_link.toggle = ~link.toggle;
		end
	end

	always_ff @(posedge ser_clk or negedge resetn) begin
		if (!resetn) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	// These only advance while the host clocks the link
	property p_shift_in;
		@(posedge ser_clk) disable iff (!resetn)
		1'b1 |=> link.shift[0] == $past(ser_data);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not captured on clock rise");

	property p_shift_order;
		@(posedge ser_clk) disable iff (!resetn)
		1'b1 |=> link.shift[WORD_BITS-1:1] == $past(link.shift[WORD_BITS-2:0]);
	endproperty
	a_shift_order: assert property (p_shift_order)
		else $error("earlier bits did not move toward the top");

	property p_latch_load;
		@(posedge ser_clk) disable iff (!resetn)
		(ser_latch && !link.latch_q && !dev_reset_link)
			|=> (link.held == $past(link.shift) && link.toggle != $past(link.toggle));
	endproperty
	a_latch_load: assert property (p_latch_load)
		else $error("latch rise did not capture the shifted word");

	property p_latch_refused;
		@(posedge ser_clk) disable iff (!resetn)
		dev_reset_link |=> ($stable(link.toggle) && $stable(link.held));
	endproperty
	a_latch_refused: assert property (p_latch_refused)
		else $error("word latched during device reset");

	logic dev_reset;
	logic latch_event;
	logic indep;
	assign dev_reset = st.rh_sync[1] | ~st.rl_sync[1];
	assign latch_event = st.tog_sync[2] ^ st.tog_sync[1];
	assign indep = st.mode_sync[1];

	always_comb begin
		logic [2:0] ac;
		logic [2:0] bc;
		next_st = st;
		ac = SEL_ZERO;
		bc = SEL_ZERO;
		next_st.tog_sync = {st.tog_sync[1:0], link.toggle};
		next_st.mode_sync = {st.mode_sync[0], mode_independent};
		next_st.rh_sync = {st.rh_sync[0], reset_hi};
		next_st.rl_sync = {st.rl_sync[0], reset_lo_n};
		if (dev_reset) begin
			next_st.valid = 1'b0;
		end else if (latch_event) begin
			next_st.word = link.held;
			next_st.valid = 1'b1;
		end
		// Word is captured once per latch; decode follows it and the mode pin
		ac = card_decode({st.word[POS_A_CARD_HI], st.word[POS_A_CARD_LO]});
		bc = card_decode({st.word[POS_B_CARD_HI], st.word[POS_B_CARD_LO]});
		if (!st.valid) begin
			next_st.a_prog = SEL_GROUND;
			next_st.b_prog = SEL_GROUND;
			next_st.a_card = SEL_GROUND;
			next_st.b_card = SEL_GROUND;
		end else if (!st.word[POS_OUTPUTS_OFF]) begin
			next_st.a_prog = SEL_HIZ;
			next_st.b_prog = SEL_HIZ;
			next_st.a_card = SEL_HIZ;
			next_st.b_card = SEL_HIZ;
		end else begin
			next_st.a_card = ac;
			next_st.b_card = bc;
			next_st.a_prog = prog_decode({st.word[POS_A_PROG_LO], st.word[POS_A_PROG_HI]},
				st.word[POS_A_LEVEL], indep, ac);
			next_st.b_prog = prog_decode({st.word[POS_B_PROG_LO], st.word[POS_B_PROG_HI]},
				st.word[POS_B_LEVEL], indep, bc);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign slot_a_prog_voltage = st.a_prog;
	assign slot_b_prog_voltage = st.b_prog;
	assign slot_a_card_voltage = st.a_card;
	assign slot_b_card_voltage = st.b_card;
	assign word_valid = st.valid;

	// Assertions
	property p_hiz_off;
		@(posedge clk) disable iff (!resetn)
		(st.valid && !st.word[POS_OUTPUTS_OFF]) |=> (slot_a_card_voltage == SEL_HIZ
			&& slot_b_prog_voltage == SEL_HIZ);
	endproperty
	a_hiz_off: assert property (p_hiz_off)
		else $error("outputs-off not high impedance");

	property p_reset_ground;
		@(posedge clk) disable iff (!resetn)
		dev_reset |=> ##1 (slot_a_card_voltage == SEL_GROUND && slot_b_card_voltage == SEL_GROUND);
	endproperty
	a_reset_ground: assert property (p_reset_ground)
		else $error("reset did not ground outputs");

	property p_hold;
		@(posedge clk) disable iff (!resetn)
		(!latch_event && !dev_reset) |=> $stable(st.word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("word changed without latch");

	property p_load;
		@(posedge clk) disable iff (!resetn)
		(latch_event && !dev_reset) |=> (st.word == $past(link.held) && word_valid);
	endproperty
	a_load: assert property (p_load)
		else $error("latch did not load word");

	property p_a_card;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && st.word[POS_A_CARD_HI:POS_A_CARD_LO] == 2'b01)
			|=> slot_a_card_voltage == SEL_3V3;
	endproperty
	a_a_card: assert property (p_a_card)
		else $error("slot A card 3.3 V decode wrong");

	property p_b_card;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && st.word[POS_B_CARD_HI]
			&& !st.word[POS_B_CARD_LO]) |=> slot_b_card_voltage == SEL_5V;
	endproperty
	a_b_card: assert property (p_b_card)
		else $error("slot B card 5 V decode wrong");

	property p_a_indep;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && indep && !st.word[POS_A_PROG_LO]
			&& st.word[POS_A_PROG_HI] && st.word[POS_A_LEVEL]) |=> slot_a_prog_voltage == SEL_5V;
	endproperty
	a_a_indep: assert property (p_a_indep)
		else $error("slot A independent decode wrong");

	property p_b_legacy;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && !indep && !st.word[POS_B_PROG_LO]
			&& st.word[POS_B_PROG_HI]) |=> slot_b_prog_voltage == slot_b_card_voltage;
	endproperty
	a_b_legacy: assert property (p_b_legacy)
		else $error("slot B legacy follow wrong");

	property p_a_indep_own;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && indep && !st.word[POS_A_PROG_LO]
			&& st.word[POS_A_PROG_HI] && !st.word[POS_A_LEVEL]
			&& st.word[POS_A_CARD_HI] && !st.word[POS_A_CARD_LO])
			|=> slot_a_prog_voltage == SEL_3V3;
	endproperty
	a_a_indep_own: assert property (p_a_indep_own)
		else $error("slot A program supply followed its card supply");

	property p_a_legacy_lvl;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && !indep && !st.word[POS_A_PROG_LO]
			&& st.word[POS_A_PROG_HI] && !st.word[POS_A_LEVEL]
			&& st.word[POS_A_CARD_HI] && !st.word[POS_A_CARD_LO])
			|=> slot_a_prog_voltage == SEL_5V;
	endproperty
	a_a_legacy_lvl: assert property (p_a_legacy_lvl)
		else $error("slot A legacy decode used the level bit");

	property p_b_indep;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && indep && !st.word[POS_B_PROG_LO]
			&& st.word[POS_B_PROG_HI] && !st.word[POS_B_LEVEL]) |=> slot_b_prog_voltage == SEL_3V3;
	endproperty
	a_b_indep: assert property (p_b_indep)
		else $error("slot B independent decode wrong");

	property p_a_card_zero;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && st.word[POS_A_CARD_HI:POS_A_CARD_LO] == 2'b11)
			|=> slot_a_card_voltage == SEL_ZERO;
	endproperty
	a_a_card_zero: assert property (p_a_card_zero)
		else $error("slot A card 11 did not give zero volts");

	property p_b_card_3v3;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && !st.word[POS_B_CARD_HI]
			&& st.word[POS_B_CARD_LO]) |=> slot_b_card_voltage == SEL_3V3;
	endproperty
	a_b_card_3v3: assert property (p_b_card_3v3)
		else $error("slot B card 3.3 V decode wrong");

	property p_a_legacy_12v;
		@(posedge clk) disable iff (!resetn)
		(st.valid && st.word[POS_OUTPUTS_OFF] && !indep && st.word[POS_A_PROG_LO]
			&& !st.word[POS_A_PROG_HI]) |=> slot_a_prog_voltage == SEL_12V;
	endproperty
	a_a_legacy_12v: assert property (p_a_legacy_12v)
		else $error("slot A legacy 12 V decode wrong");

	property p_no_word_ground;
		@(posedge clk) disable iff (!resetn)
		!st.valid |=> (slot_a_prog_voltage == SEL_GROUND && slot_b_prog_voltage == SEL_GROUND);
	endproperty
	a_no_word_ground: assert property (p_no_word_ground)
		else $error("program supplies not grounded without a word");

endmodule : card_power_switch_decoder

// File: testbench/host_serial_model.sv
// Host controller model that shifts control words into the switch decoder
module host_serial_model (
	output logic ser_clk, // Serial clock, still between frames
	output logic ser_data, // Serial data
	output logic ser_latch // Latch strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_latch = 1'b0;
	end
	// Highest bit first, one bit per rising serial clock
	task automatic send_word(input logic [10:0] w);
		#13;
		for (int i = 10; i >= 0; i--) begin
			ser_data = w[i];
			#32 ser_clk = 1'b1;
			#32 ser_clk = 1'b0;
		end
		// Latch rises ahead of the next clock rise; data is no longer valid
		ser_latch = 1'b1;
		ser_data = ~ser_data;
		#32 ser_clk = 1'b1;
		#32 ser_clk = 1'b0;
		ser_latch = 1'b0;
		ser_data = ~ser_data;
	endtask : send_word
endmodule : host_serial_model

// File: testbench/card_power_switch_decoder_tb.sv
// Self-checking bench for the card supply switch decoder
module card_power_switch_decoder_tb
	import supply_switch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, mode_independent, reset_hi, reset_lo_n;
	logic ser_clk, ser_data, ser_latch, word_valid;
	logic [2:0] slot_a_prog_voltage, slot_b_prog_voltage;
	logic [2:0] slot_a_card_voltage, slot_b_card_voltage;
	int n_errors;
	int cmp_count;
	host_serial_model u_host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
	card_power_switch_decoder u_dut (.clk(clk), .resetn(resetn), .ser_clk(ser_clk),
		.ser_data(ser_data), .ser_latch(ser_latch), .mode_independent(mode_independent),
		.reset_hi(reset_hi), .reset_lo_n(reset_lo_n), .slot_a_prog_voltage(slot_a_prog_voltage),
		.slot_b_prog_voltage(slot_b_prog_voltage), .slot_a_card_voltage(slot_a_card_voltage),
		.slot_b_card_voltage(slot_b_card_voltage), .word_valid(word_valid));
	function automatic logic [2:0] card_sel(input logic hi, input logic lo, input logic on);
		if (!on) return SEL_HIZ;
		case ({hi, lo})
			2'b01: return SEL_3V3;
			2'b10: return SEL_5V;
			default: return SEL_ZERO;
		endcase
	endfunction : card_sel
	function automatic logic [2:0] prog_sel(input logic b0, input logic b1, input logic lvl,
		input logic on, input logic indep, input logic [2:0] card);
		if (!on) return SEL_HIZ;
		case ({b0, b1})
			2'b00: return SEL_ZERO;
			2'b01: return indep ? (lvl ? SEL_5V : SEL_3V3) : card;
			2'b10: return SEL_12V;
			default: return SEL_HIZ;
		endcase
	endfunction : prog_sel
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic check_word(input logic [10:0] w, input logic m);
		logic [2:0] ac, bc;
		ac = card_sel(w[3], w[2], w[8]);
		bc = card_sel(w[6], w[7], w[8]);
		check(slot_a_card_voltage, ac);
		check(slot_b_card_voltage, bc);
		check(slot_a_prog_voltage, prog_sel(w[0], w[1], w[9], w[8], m, ac));
		check(slot_b_prog_voltage, prog_sel(w[4], w[5], w[10], w[8], m, bc));
		check({2'b00, word_valid}, 3'h1);
	endtask : check_word
	task automatic check_ground();
		check(slot_a_prog_voltage, SEL_GROUND);
		check(slot_b_prog_voltage, SEL_GROUND);
		check(slot_a_card_voltage, SEL_GROUND);
		check(slot_b_card_voltage, SEL_GROUND);
		check({2'b00, word_valid}, 3'h0);
	endtask : check_ground
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cycles
	task automatic complete_run();
		$display("Comparisons %0d, errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog so a hang still reaches the verdict
	initial begin
		#400us;
		n_errors++;
		complete_run();
	end
	initial begin
		logic [10:0] w, prev;
		logic m, pm;
		resetn = 1'b0;
		mode_independent = 1'b0;
		reset_hi = 1'b0;
		reset_lo_n = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		void'($urandom(4356));
		cycles(10);
		check_ground();
		resetn = 1'b1;
		cycles(2);
		prev = 11'h000;
		pm = 1'b0;
		for (int n = 0; n < 40; n++) begin
			w = 11'($urandom);
			m = 1'($urandom);
			// First words walk every supply and level field code in both modes
			if (n < 16) begin
				w = {n[2], n[2], 1'b1, n[1], n[0], n[0], n[1], n[0], n[1], n[0], n[1]};
				m = n[3];
			end
			// Old selections must hold while the next word shifts in
			fork
				u_host.send_word(w);
				begin
					cycles(20);
					if (n > 0) check_word(prev, pm);
					mode_independent = m;
				end
			join
			cycles(10);
			check_word(w, m);
			prev = w;
			pm = m;
		end
		for (int k = 0; k < 2; k++) begin
			if (k == 0) reset_hi = 1'b1;
			else reset_lo_n = 1'b0;
			cycles(6);
			check_ground();
			u_host.send_word(11'h1e9);
			cycles(10);
			check_ground();
			reset_hi = 1'b0;
			reset_lo_n = 1'b1;
			cycles(10);
			check_ground();
			w = 11'($urandom) | 11'h100;
			u_host.send_word(w);
			cycles(10);
			check_word(w, m);
		end
		resetn = 1'b0;
		#3;
		check_ground();
		cycles(2);
		resetn = 1'b1;
		cycles(2);
		check_ground();
		complete_run();
	end
endmodule : card_power_switch_decoder_tb
